// *** src/nbtt_bcd_addsub.sv ***
// Decimal adder and subtractor for one counter group.
// Assumes BCD operands; subtraction wraps as a tens complement counter.
`timescale 1ns/10ps
`include "nbtt_params.svh"
module nbtt_bcd_addsub
    import nbtt_pkg::*;
#(
    parameter int DIGITS = `NBTT_DIGITS
) (
    // Operands.
    input wire logic [DIGITS*4-1:0] a_i,
    input wire logic [DIGITS*4-1:0] b_i,
    input wire logic sub_i,
    // Result.
    output logic [DIGITS*4-1:0] sum_o
);
    logic [DIGITS:0] carry;
    assign carry[0] = sub_i;
    // Subtraction adds the nines complement plus one, as the counters do.
    genvar g;
    generate
        for (g = 0; g < DIGITS; g++) begin : g_dig
            logic [3:0] bd;
            logic [4:0] raw;
            assign bd = sub_i ? (4'h9 - b_i[g*4 +: 4]) : b_i[g*4 +: 4];
            assign raw = {1'b0, a_i[g*4 +: 4]} + {1'b0, bd} + {4'h0, carry[g]};
            assign carry[g+1] = (raw > 5'h09);
            assign sum_o[g*4 +: 4] = (raw > 5'h09) ? 4'(raw - 5'h0a) : raw[3:0];
        end
    endgenerate
endmodule

// *** src/nbtt_core.sv ***
// Net balance total control: minor, intermediate and major counter groups.
// Assumes card, program and punch strobes are synchronous one-cycle pulses
// except the punch status levels, which come from the attached punch's pins.
// Overview of operation
// - Credit mark exit pulses on subtract card cycles and credit total cycles.
// - Zero from real entries may show credit; zero from no entries never does.
// - Only minor takes cards; minor rolls to intermediate, intermediate to major.
// - Receiver accumulates only with plus or minus entry and transfer enabled.
// - Each group has plus and minus transfer outputs, active at the late impulse of its total cycle.
// - At minor program start test sign; negative drives minus transfer output.
// - Positive sign keeps negative flag clear and drives plus transfer output.
// - Digit nine high order sets negative flag; total waits for conversion.
// - Plus transfer output carries the late impulse during the total cycle.
// - Minus transfer output carries the late impulse during the total cycle.
// - Negative total is converted to true figure, then subtracted into receiver.
// - Progressive readout prints the total without clearing it.
// - After progressive readout, following entries build on the kept total.
// - Start and run blocked while punch hopper empty, misfeeds, or not run in.
// - At punch break suspend total, idle while punching, then resume printing.
// - Net balance with negative total converts before punching starts.
// - Only values held in counters are offered for punching.
// - Transfer outputs also command an X punch for negative totals.
// - Transfer outputs stay low unless built with the negative balance feature.
`timescale 1ns/10ps
`include "nbtt_params.svh"
module nbtt_core
    import nbtt_pkg::*;
#(
    parameter int DIGITS = `NBTT_DIGITS,
    parameter bit NEG_BALANCE = 1'b1
) (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Card entries to the minor group.
    input wire logic card_cycle_i,
    input wire logic card_sub_i,
    input wire logic [DIGITS*4-1:0] card_amount_i,
    // Program level strobes: 0 minor, 1 intermediate, 2 major.
    input wire logic [2:0] program_i,
    input wire logic late_impulse_i,
    // Configuration levels.
    input wire logic net_balance_i,
    input wire logic zero_credit_i,
    input wire logic [1:0] transfer_en_i,
    input wire logic [1:0] plus_entry_i,
    input wire logic [1:0] minus_entry_i,
    input wire logic progressive_i,
    input wire logic punch_break_i,
    // Attached punch pins.
    input wire logic punch_attached_i,
    input wire logic punch_hopper_empty_i,
    input wire logic punch_feed_fail_i,
    input wire logic punch_run_in_i,
    input wire logic punch_done_i,
    // Outputs.
    output logic run_enable_o,
    output logic punch_request_o,
    output logic [DIGITS*4-1:0] punch_value_o,
    output logic credit_mark_exit_o,
    output logic [DIGITS*4-1:0] print_value_o,
    output logic print_strobe_o,
    output logic [2:0] transfer_plus_o,
    output logic [2:0] transfer_minus_o,
    output logic [2:0] transfer_punch_x_output_o,
    output logic busy_o
);
    localparam int W = DIGITS*4;

    // Punch pin synchronisers; only the second stage is read.
    logic [4:0] pin_s1;
    logic [4:0] pin_s2;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_s1 <= 5'h00;
            pin_s2 <= 5'h00;
        end else begin
            pin_s1 <= {punch_attached_i, punch_hopper_empty_i, punch_feed_fail_i,
                       punch_run_in_i, punch_done_i};
            pin_s2 <= pin_s1;
        end
    end
    logic p_attached;
    logic p_empty;
    logic p_fail;
    logic p_runin;
    logic p_done;
    assign {p_attached, p_empty, p_fail, p_runin, p_done} = pin_s2;

    // Without a punch attached the interlock is open; with one, any fault stops us.
    assign run_enable_o = !p_attached || (!p_empty && !p_fail && p_runin);

    // Counter groups and their entry flags.
    logic [W-1:0] ctr [3];
    logic [2:0] entered;
    logic [2:0] negative;
    nbtt_state_t state;
    nbtt_state_t next_state;
    logic [1:0] grp;
    logic converted;

    // Shared decimal unit: a card entry, a roll, or a conversion.
    logic [W-1:0] au_a;
    logic [W-1:0] au_b;
    logic au_sub;
    logic [W-1:0] au_sum;
    nbtt_bcd_addsub #(.DIGITS(DIGITS)) u_addsub (
        .a_i(au_a),
        .b_i(au_b),
        .sub_i(au_sub),
        .sum_o(au_sum)
    );

    // Operand selection follows the state; the card path is used when idle.
    logic [1:0] rcv;
    logic do_roll;
    logic roll_neg;
    logic rcv_plus;
    logic rcv_minus;
    assign rcv = grp + 2'd1;
    assign rcv_plus = (grp < 2'd2) ? plus_entry_i[grp[0]] : 1'b0;
    assign rcv_minus = (grp < 2'd2) ? minus_entry_i[grp[0]] : 1'b0;
    assign roll_neg = negative[grp];
    // A negative total enters through the minus entry, a positive one through plus.
    assign do_roll = (grp < 2'd2) && transfer_en_i[grp[0]]
                     && (roll_neg ? rcv_minus : rcv_plus);
    always_comb begin
        au_a = ctr[0];
        au_b = card_amount_i;
        au_sub = card_sub_i;
        case (state)
            NBTT_CONV: begin
                // Converting the complement: 0 - complement gives the true figure.
                au_a = '0;
                au_b = ctr[grp];
                au_sub = 1'b1;
            end
            NBTT_TOTAL: begin
                // The roll adds at the late impulse, while the sender still holds its total.
                au_a = ctr[rcv];
                au_b = ctr[grp];
                au_sub = roll_neg;
            end
            default: begin
                au_a = ctr[0];
                au_b = card_amount_i;
                au_sub = card_sub_i;
            end
        endcase
    end

    // Sign test of the selected group's high order digit.
    logic hi_nine;
    assign hi_nine = (ctr[grp][W-1 -: 4] == `NBTT_NEG_DIGIT);

    // Keep the total whenever readout is progressive.
    logic keep_total;
    assign keep_total = progressive_i;

    // Sequencer state register.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= NBTT_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Program sequence: test, convert, punch, total print, roll.
    always_comb begin
        next_state = state;
        case (state)
            NBTT_IDLE: begin
                if (program_i != 3'b000) begin
                    next_state = NBTT_TEST;
                end
            end
            NBTT_TEST: begin
                // Negative totals defer the total until the conversion is done.
                if (NEG_BALANCE && net_balance_i && hi_nine && !converted) begin
                    next_state = NBTT_CONV;
                end else if (punch_break_i && p_attached) begin
                    next_state = NBTT_PUNCH;
                end else begin
                    next_state = NBTT_TOTAL;
                end
            end
            NBTT_CONV: begin
                next_state = NBTT_TEST;
            end
            NBTT_PUNCH: begin
                // The total cycle idles here until the punch reports completion.
                if (p_done) begin
                    next_state = NBTT_TOTAL;
                end
            end
            NBTT_TOTAL: begin
                if (late_impulse_i) begin
                    next_state = NBTT_ROLL;
                end
            end
            NBTT_ROLL: begin
                // A held higher level totals the next group before returning to idle.
                if (grp < 2'd2 && program_i_hold[rcv]) begin
                    next_state = NBTT_TEST;
                end else begin
                    next_state = NBTT_DONE;
                end
            end
            NBTT_DONE: begin
                next_state = NBTT_IDLE;
            end
            default: begin
                next_state = NBTT_IDLE;
            end
        endcase
    end

    // Program levels are held across the sequence so higher groups follow.
    logic [2:0] program_i_hold;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            program_i_hold <= 3'b000;
        end else if (state == NBTT_IDLE) begin
            program_i_hold <= program_i;
        end
    end

    // Group pointer: the lowest program level strobed picks the first group to total.
    // The next higher level follows once the roll is done, only if it is held; a gap in the held levels ends the sequence.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            grp <= 2'd0;
        end else if (state == NBTT_IDLE && program_i != 3'b000) begin
            if (program_i[0]) begin
                grp <= 2'd0;
            end else if (program_i[1]) begin
                grp <= 2'd1;
            end else begin
                grp <= 2'd2;
            end
        end else if (state == NBTT_DONE) begin
            grp <= 2'd0;
        end else if (state == NBTT_ROLL && grp < 2'd2 && program_i_hold[rcv]) begin
            grp <= rcv;
        end
    end

    // Negative flags: set by a test finding nine, cleared on a positive test.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            negative <= 3'b000;
            converted <= 1'b0;
        end else if (state == NBTT_TEST && !converted) begin
            negative[grp] <= NEG_BALANCE && net_balance_i && hi_nine;
        end else if (state == NBTT_CONV) begin
            converted <= 1'b1;
        end else if (state == NBTT_ROLL || state == NBTT_DONE) begin
            converted <= 1'b0;
        end
    end

    // Counters: cards go to minor only; rolls add into the receiver.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctr[0] <= '0;
            ctr[1] <= '0;
            ctr[2] <= '0;
            entered <= 3'b000;
        end else begin
            case (state)
                NBTT_IDLE: begin
                    if (card_cycle_i) begin
                        ctr[0] <= au_sum;
                        entered[0] <= 1'b1;
                    end
                end
                NBTT_CONV: begin
                    ctr[grp] <= au_sum;
                end
                NBTT_TOTAL: begin
                    // The receiver adds at the late impulse, while its entry is energized;
                    // the entries are gone again by the next cycle.
                    if (late_impulse_i && do_roll) begin
                        ctr[rcv] <= au_sum;
                        entered[rcv] <= 1'b1;
                    end
                end
                NBTT_ROLL: begin
                    // The sending group clears unless readout is progressive.
                    if (!keep_total) begin
                        ctr[grp] <= '0;
                        entered[grp] <= 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Print and punch data come from registered counter contents.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            print_value_o <= '0;
            print_strobe_o <= 1'b0;
            punch_value_o <= '0;
        end else begin
            print_strobe_o <= (state == NBTT_TOTAL) && late_impulse_i;
            if (state == NBTT_TOTAL) begin
                print_value_o <= ctr[grp];
            end
            if (state == NBTT_TEST) begin
                punch_value_o <= ctr[grp];
            end
        end
    end
    assign punch_request_o = (state == NBTT_PUNCH);
    assign busy_o = (state != NBTT_IDLE);

    // Credit mark: subtract cards, or a credit total; zero with no entries is silent.
    logic credit_total;
    assign credit_total = negative[grp]
        || (zero_credit_i && entered[grp] && ctr[grp] == '0);
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            credit_mark_exit_o <= 1'b0;
        end else begin
            credit_mark_exit_o <= (state == NBTT_IDLE && card_cycle_i && card_sub_i)
                || (state == NBTT_TOTAL && late_impulse_i && credit_total);
        end
    end

    // Transfer outputs pulse with the late impulse of the clearing group's total.
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_xfer
            logic act;
            assign act = NEG_BALANCE && state == NBTT_TOTAL
                         && grp == 2'(g) && late_impulse_i;
            assign transfer_plus_o[g] = act && !negative[g];
            assign transfer_minus_o[g] = act && negative[g];
            assign transfer_punch_x_output_o[g] = act && negative[g];
        end
    endgenerate
endmodule

// *** src/nbtt_params.svh ***
// Constants for the net balance total transfer block.
// Assumes inclusion by bare name from design files only.
`ifndef NBTT_PARAMS_SVH
`define NBTT_PARAMS_SVH
`define NBTT_DIGITS 6
`define NBTT_NEG_DIGIT 4'h9
`define NBTT_GROUPS 3
`endif

// *** src/nbtt_pkg.sv ***
// Types shared by the net balance total transfer block.
// Assumes nbtt_params.svh is on the include path.
`include "nbtt_params.svh"
package nbtt_pkg;
    typedef enum logic [6:0] {
        NBTT_IDLE  = 7'h01,
        NBTT_TEST  = 7'h02,
        NBTT_CONV  = 7'h04,
        NBTT_PUNCH = 7'h08,
        NBTT_TOTAL = 7'h10,
        NBTT_ROLL  = 7'h20,
        NBTT_DONE  = 7'h40
    } nbtt_state_t;
    typedef logic [`NBTT_DIGITS*4-1:0] nbtt_bcd_t;
endpackage

// *** verif/nbtt_core_asserts.sv ***
// Concurrent checks on the ports of the net balance total block.
// Assumes one clock domain and the block's two-flop pin synchronisers.
`timescale 1ns/10ps
module nbtt_core_asserts (
    // Clock, reset and inputs.
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic card_cycle_i,
    input wire logic card_sub_i,
    input wire logic [2:0] program_i,
    input wire logic late_impulse_i,
    input wire logic punch_attached_i,
    input wire logic punch_hopper_empty_i,
    input wire logic punch_feed_fail_i,
    input wire logic punch_run_in_i,
    // Outputs.
    input wire logic run_enable_o,
    input wire logic punch_request_o,
    input wire logic credit_mark_exit_o,
    input wire logic print_strobe_o,
    input wire logic [2:0] transfer_plus_o,
    input wire logic [2:0] transfer_minus_o,
    input wire logic [2:0] transfer_punch_x_output_o,
    input wire logic busy_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    // A transfer impulse, then a one-cycle print strobe.
    sequence s_xfer;
        late_impulse_i && (transfer_plus_o != 3'h0 || transfer_minus_o != 3'h0);
    endsequence
    sequence s_print;
        print_strobe_o ##1 !print_strobe_o;
    endsequence

    AST_X_MIRROR: assert property (transfer_punch_x_output_o == transfer_minus_o)
        else $error("x punch output differs from minus transfer");
    AST_XFER_LATE: assert property (s_xfer or !(|{transfer_plus_o, transfer_minus_o}))
        else $error("transfer output without late impulse");
    AST_XFER_ONE: assert property ($onehot0({transfer_plus_o, transfer_minus_o}))
        else $error("more than one transfer output active");
    AST_XFER_PRINT: assert property (s_xfer |=> s_print)
        else $error("no print strobe after transfer");
    AST_CARD_SUB: assert property (card_cycle_i && card_sub_i && !busy_o |=> credit_mark_exit_o)
        else $error("no credit mark after subtract card");
    AST_CARD_ADD: assert property (card_cycle_i && !card_sub_i && !busy_o |=> !credit_mark_exit_o)
        else $error("credit mark after add card");
    AST_START: assert property (program_i != 3'h0 && !busy_o |=> busy_o [*2])
        else $error("program level did not start a total");
    AST_HOLD: assert property ((punch_attached_i && (punch_hopper_empty_i || punch_feed_fail_i
        || !punch_run_in_i)) [*3] |-> !run_enable_o)
        else $error("run enabled while punch not ready");
    AST_PUNCH: assert property (punch_request_o |-> busy_o && !(|transfer_plus_o))
        else $error("total cycle ran during punching");
endmodule

bind nbtt_core nbtt_core_asserts i_nbtt_core_asserts (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .card_cycle_i(card_cycle_i),
    .card_sub_i(card_sub_i), .program_i(program_i), .late_impulse_i(late_impulse_i),
    .punch_attached_i(punch_attached_i), .punch_hopper_empty_i(punch_hopper_empty_i),
    .punch_feed_fail_i(punch_feed_fail_i), .punch_run_in_i(punch_run_in_i),
    .run_enable_o(run_enable_o), .punch_request_o(punch_request_o),
    .credit_mark_exit_o(credit_mark_exit_o), .print_strobe_o(print_strobe_o),
    .transfer_plus_o(transfer_plus_o), .transfer_minus_o(transfer_minus_o),
    .transfer_punch_x_output_o(transfer_punch_x_output_o), .busy_o(busy_o));

// *** verif/nbtt_punch_model.sv ***
// Behavioural model of the attached summary punch.
// Assumes the block's punch pins and a bench that commands faults and delay.
`timescale 1ns/10ps
module nbtt_punch_model (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Bench commands: bit 0 hopper empty, 1 misfeed, 2 not run in.
    input wire logic punch_request_i,
    input wire logic [2:0] fault_i,
    input wire logic [3:0] delay_i,
    // Punch pins.
    output logic punch_attached_o,
    output logic punch_hopper_empty_o,
    output logic punch_feed_fail_o,
    output logic punch_run_in_o,
    output logic punch_done_o
);
    logic [3:0] cnt;

    // Card lever levels go straight to the pins; the block must stop on any of them.
    assign punch_attached_o = 1'b1;
    assign punch_hopper_empty_o = fault_i[0];
    assign punch_feed_fail_o = fault_i[1];
    assign punch_run_in_o = ~fault_i[2];

    // Punching takes delay_i plus one cycles; done holds until the request is withdrawn.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= 4'h0;
            punch_done_o <= 1'b0;
        end else if (!punch_request_i) begin
            cnt <= 4'h0;
            punch_done_o <= 1'b0;
        end else if (cnt == delay_i) begin
            punch_done_o <= 1'b1;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the net balance total block and the punch model.
// Assumes the package and design sources are compiled first.
`timescale 1ns/10ps
module tb;
    import nbtt_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic card_cycle_i = 1'b0;
    logic card_sub_i = 1'b0;
    logic late_impulse_i = 1'b0;
    logic xen = 1'b0;
    logic prog = 1'b0;
    logic brk = 1'b0;
    logic [2:0] program_i = 3'h0;
    logic [2:0] fault = 3'h0;
    logic [3:0] dly = 4'h1;
    nbtt_bcd_t card_amount_i = '0;
    logic attached, empty, fail, run_in, done, run_en, preq, credit, pstb, busy;
    logic [2:0] tp, tm;
    nbtt_bcd_t pval, prv;
    int miscompares = 0;
    int checks = 0;
    int seed = 32'hd4ab;
    int m = 0;
    int n = 0;

    always #2.5 clk_sys_i = ~clk_sys_i;

    // The transfer outputs are wired back to the entries, as a control panel would be.
    nbtt_core i_nbtt_core (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .card_cycle_i(card_cycle_i),
        .card_sub_i(card_sub_i), .card_amount_i(card_amount_i), .program_i(program_i),
        .late_impulse_i(late_impulse_i), .net_balance_i(1'b1), .zero_credit_i(1'b1),
        .transfer_en_i({2{xen}}), .plus_entry_i(tp[1:0] | {2{prog}}),
        .minus_entry_i(tm[1:0] | {2{prog}}), .progressive_i(prog),
        .punch_break_i(brk), .punch_attached_i(attached), .punch_hopper_empty_i(empty),
        .punch_feed_fail_i(fail), .punch_run_in_i(run_in), .punch_done_i(done),
        .run_enable_o(run_en), .punch_request_o(preq), .punch_value_o(pval),
        .credit_mark_exit_o(credit), .print_value_o(prv), .print_strobe_o(pstb),
        .transfer_plus_o(tp), .transfer_minus_o(tm), .transfer_punch_x_output_o(),
        .busy_o(busy));

    nbtt_punch_model i_nbtt_punch_model (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .punch_request_i(preq),
        .fault_i(fault), .delay_i(dly), .punch_attached_o(attached),
        .punch_hopper_empty_o(empty), .punch_feed_fail_o(fail),
        .punch_run_in_o(run_in), .punch_done_o(done));

    // Magnitude as BCD; a negative total is expected to print as its true figure.
    function automatic nbtt_bcd_t bcd(input int v);
        nbtt_bcd_t r;
        int a;
        a = (v < 0) ? -v : v;
        for (int d = 0; d < $bits(nbtt_bcd_t) / 4; d++) begin
            r[d*4 +: 4] = 4'(a % 10);
            a = a / 10;
        end
        return r;
    endfunction

    task automatic complete_run;
        if (miscompares == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input nbtt_bcd_t seen, input nbtt_bcd_t exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic hang;
        miscompares++;
        $display("[ERR] %0t wait ran out", $time);
        complete_run;
    endtask

    task automatic tick;
        @(posedge clk_sys_i);
        #1;
    endtask

    // One card cycle; a gap cycle follows so the strobe is never driven twice at once.
    task automatic card(input logic sub, input int amt);
        card_cycle_i = 1'b1;
        card_sub_i = sub;
        card_amount_i = bcd(amt);
        tick;
        check(nbtt_bcd_t'(credit), nbtt_bcd_t'(sub));
        card_cycle_i = 1'b0;
        m = sub ? m - amt : m + amt;
        tick;
    endtask

    // Runs one total of group lvl, whose expected balance is v; fed tells if it had entries.
    task automatic total(input int lvl, input int v, input bit fed);
        int i;
        logic pseen;
        i = 0;
        pseen = 1'b0;
        program_i = 3'(1 << lvl);
        tick;
        program_i = 3'h0;
        late_impulse_i = 1'b1;
        while ((tp | tm) === 3'h0 && i < 200) begin
            if (preq === 1'b1 && !pseen) begin
                check(pval, bcd(v));
                pseen = 1'b1;
            end
            tick;
            i++;
        end
        if (i == 200) hang;
        check(nbtt_bcd_t'(pseen), nbtt_bcd_t'(brk));
        check(nbtt_bcd_t'(tm[lvl]), nbtt_bcd_t'(v < 0));
        check(nbtt_bcd_t'(tp[lvl]), nbtt_bcd_t'(v >= 0));
        tick;
        late_impulse_i = 1'b0;
        check(nbtt_bcd_t'(pstb), nbtt_bcd_t'(1'b1));
        check(prv, bcd(v));
        check(nbtt_bcd_t'(credit), nbtt_bcd_t'(v < 0 || (v == 0 && fed)));
        i = 0;
        while (busy !== 1'b0 && i < 100) begin
            tick;
            i++;
        end
        if (i == 100) hang;
    endtask

    // Interlock, then transfer rounds, then progressive totals.
    initial begin
        repeat (5) @(posedge clk_sys_i);
        #1;
        rst_n_i = 1'b1;
        tick;
        for (int k = 0; k < 3; k++) begin
            fault = 3'(1 << k);
            repeat (4) tick;
            check(nbtt_bcd_t'(run_en), nbtt_bcd_t'(1'b0));
            fault = 3'h0;
            repeat (4) tick;
            check(nbtt_bcd_t'(run_en), nbtt_bcd_t'(1'b1));
        end
        xen = 1'b1;
        for (int r = 0; r < 6; r++) begin
            brk = (r == 0 || r == 3);
            dly = (r == 0) ? 4'h6 : 4'h1;
            if (r == 0) card(1'b1, 300);
            else if (r == 1) card(1'b0, 900);
            else repeat (3) card(($random(seed) & 3) == 0, {$random(seed)} % 1000);
            total(0, m, 1'b1);
            n = n + m;
            m = 0;
        end
        brk = 1'b0;
        total(1, n, 1'b1);
        total(0, 0, 1'b0);
        xen = 1'b0;
        prog = 1'b1;
        card(1'b0, 250);
        total(0, m, 1'b1);
        card(1'b0, 17);
        total(0, m, 1'b1);
        complete_run;
    end
endmodule
